// ---- core/e3ntx_fifo.v ----
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module e3ntx_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_reg];
  assign level     = count_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // e3ntx_fifo
`default_nettype wire

// ---- core/e3ntx_payload_in.v ----
// E3 nibble-parallel transmit payload input, local-timed modes 5 and 6
`timescale 1ns/10ps
`default_nettype none
`include "e3ntx_defines.vh"
module e3ntx_payload_in (
  input  wire        CLK,
  input  wire        NRST,
  input  wire [7:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  input  wire        NIBBLE_INTF_EN,
  input  wire [3:0]  TX_PAYLOAD_NIBBLE,
  input  wire        TX_FRAME_REF_IN,
  output reg         TX_NIBBLE_CLOCK_OUT,
  output reg         TX_FRAME_BOUNDARY_OUT,
  output wire        TX_OVERHEAD_INDICATOR,
  output reg  [3:0]  NIB_DATA,
  output reg         NIB_OVERHEAD,
  output reg         NIB_FIRST,
  output wire        NIB_VALID,
  input  wire        NIB_READY,
  output wire        TX_ACTIVE
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg  [7:0] mode_reg;
  reg  [1:0] div_reg;
  reg  [1:0] smp_cnt_reg;
  reg        smp_arm_reg;
  reg  [8:0] nib_cnt_reg;
  reg  [1:0] bit_cnt_reg;
  reg        ref_d_reg;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg        overrun_reg;
  reg  [3:0] out_nib_reg;
  reg        out_oh_reg;
  reg        out_first_reg;
  reg        out_vld_reg;
  wire       nib_mode;
  wire       slave_mode;
  wire       master_mode;
  wire       run;
  wire       tick;
  wire       ref_rise;
  wire       sample;
  wire       frame_start;
  wire       oh_slot;
  wire       fifo_in_ready;
  wire [3:0] fifo_q;
  wire       fifo_v;
  wire       fifo_pop;
  wire       fifo_q_oh;
  wire       fifo_q_first;
  wire [5:0] fifo_word;
  wire [3:0] fifo_level;

  // Nibble mode needs the pin high; select 01 slave, 1X master
  assign nib_mode    = NIBBLE_INTF_EN & ~mode_reg[`E3NTX_B_SWRESET] &
                       (mode_reg[`E3NTX_B_SEL_HI:`E3NTX_B_SEL_LO] != `E3NTX_SEL_OFF);
  assign master_mode = nib_mode & mode_reg[`E3NTX_B_SEL_HI];
  assign slave_mode  = nib_mode &
                       (mode_reg[`E3NTX_B_SEL_HI:`E3NTX_B_SEL_LO] == `E3NTX_SEL_SLAVE);
  assign run         = (state_reg == ST_RUN);
  assign TX_ACTIVE   = run;

  // Overhead always internal; indicator held low in these modes
  assign TX_OVERHEAD_INDICATOR = 1'b0;

  // Register port: mode word is the only register that takes write data; a status write clears overrun
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_reg <= `E3NTX_MODE_RESET;
    end else if (WR && ADDR == `E3NTX_ADDR_MODE) begin
      mode_reg <= WDATA;
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `E3NTX_ADDR_MODE:   RDATA <= mode_reg;
        `E3NTX_ADDR_STATUS: RDATA <= {overrun_reg, fifo_level, state_reg};
        `E3NTX_ADDR_NIBBLE: RDATA <= {nib_cnt_reg[8:1]};
        default:            RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Divide-by-four, one pulse per four reference periods
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      div_reg             <= 2'h0;
      TX_NIBBLE_CLOCK_OUT <= 1'b0;
    end else if (!nib_mode || frame_start) begin
      div_reg             <= 2'h0;
      TX_NIBBLE_CLOCK_OUT <= 1'b0;
    end else begin
      div_reg             <= div_reg + 2'h1;
      // Held low until the first tick, so in master mode no edge comes without a capture
      TX_NIBBLE_CLOCK_OUT <= (div_reg == `E3NTX_DIV) |
                             ((div_reg == 2'h0) & TX_NIBBLE_CLOCK_OUT);
    end
  end
  // Rising edge of the output clock, as the block itself sees it
  assign tick = nib_mode && (div_reg == `E3NTX_DIV) && !frame_start;

  // Frame reference edge; slave mode only
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ref_d_reg <= 1'b0;
    end else begin
      ref_d_reg <= TX_FRAME_REF_IN;
    end
  end
  assign ref_rise    = slave_mode & TX_FRAME_REF_IN & ~ref_d_reg;
  assign frame_start = ref_rise; // Mid-frame edge restarts too

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (master_mode) begin
          state_next = ST_RUN; // Free-running, no external sync
        end else if (slave_mode) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!slave_mode) begin
          state_next = ST_IDLE;
        end else if (frame_start) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!nib_mode) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Nibble and bit counters; 384 nibbles of 4 bits per frame
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      nib_cnt_reg <= 9'h000;
      bit_cnt_reg <= 2'h0;
    end else if (frame_start || state_next != ST_RUN || !run) begin
      nib_cnt_reg <= 9'h000;
      bit_cnt_reg <= 2'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 2'h1;
      // Advance on capture, so the first nibble after a start is slot zero
      if (sample) begin
        nib_cnt_reg <= (nib_cnt_reg == `E3NTX_NIB_LAST) ? 9'h000 :
                       nib_cnt_reg + 9'h001;
      end
    end
  end

  // Last bit of the frame marks the boundary in master mode
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TX_FRAME_BOUNDARY_OUT <= 1'b0;
    end else begin
      TX_FRAME_BOUNDARY_OUT <= master_mode && run && !frame_start &&
                               (nib_cnt_reg == `E3NTX_NIB_LAST) &&
                               (bit_cnt_reg == `E3NTX_DIV_HALF);
    end
  end

  // Capture three reference edges after the nibble clock pulse
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      smp_arm_reg <= 1'b0;
      smp_cnt_reg <= 2'h0;
    end else if (!run || frame_start) begin
      smp_arm_reg <= 1'b0;
      smp_cnt_reg <= 2'h0;
    end else if (tick) begin
      smp_arm_reg <= 1'b1;
      smp_cnt_reg <= 2'h1;
    end else if (smp_arm_reg) begin
      smp_cnt_reg <= smp_cnt_reg + 2'h1;
      if (smp_cnt_reg == `E3NTX_SAMPLE_DLY - 2'h1) begin
        smp_arm_reg <= 1'b0;
      end
    end
  end
  assign sample  = smp_arm_reg && (smp_cnt_reg == `E3NTX_SAMPLE_DLY - 2'h1);
  // First three nibbles carry the 12 overhead bits, made here
  assign oh_slot = (nib_cnt_reg < `E3NTX_OH_NIBBLES);

  // Captured nibble is pushed; overhead slots carry zero nibbles
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out_nib_reg   <= 4'h0;
      out_oh_reg    <= 1'b0;
      out_first_reg <= 1'b0;
      out_vld_reg   <= 1'b0;
    end else begin
      out_vld_reg <= sample;
      if (sample) begin
        out_nib_reg   <= oh_slot ? 4'h0 : TX_PAYLOAD_NIBBLE;
        out_oh_reg    <= oh_slot;
        out_first_reg <= (nib_cnt_reg == 9'h000);
      end
    end
  end

  // Overrun is sticky; a full FIFO drops the nibble rather than stall the line
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      overrun_reg <= 1'b0;
    end else if (out_vld_reg && !fifo_in_ready) begin
      overrun_reg <= 1'b1;
    end else if (WR && ADDR == `E3NTX_ADDR_STATUS) begin
      overrun_reg <= 1'b0;
    end
  end

  e3ntx_fifo #(
    .WIDTH (6),
    .DEPTH (`E3NTX_FIFO_DEPTH),
    .AW    (`E3NTX_FIFO_AW)
  ) u_fifo (
    .clk       (CLK),
    .nrst      (NRST),
    .flush     (!nib_mode),
    .in_data   ({out_first_reg, out_oh_reg, out_nib_reg}),
    .in_valid  (out_vld_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_v),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );
  assign fifo_q       = fifo_word[3:0];
  assign fifo_q_oh    = fifo_word[4];
  assign fifo_q_first = fifo_word[5];

  // Output stage: data from flip-flops, valid/ready handshake
  reg out_stage_v_reg;
  assign NIB_VALID = out_stage_v_reg;
  assign fifo_pop  = fifo_v && (!out_stage_v_reg || NIB_READY);
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out_stage_v_reg <= 1'b0;
      NIB_DATA        <= 4'h0;
      NIB_OVERHEAD    <= 1'b0;
      NIB_FIRST       <= 1'b0;
    end else if (!nib_mode) begin
      out_stage_v_reg <= 1'b0;
    end else if (fifo_pop) begin
      out_stage_v_reg <= 1'b1;
      NIB_DATA        <= fifo_q;
      NIB_OVERHEAD    <= fifo_q_oh;
      NIB_FIRST       <= fifo_q_first;
    end else if (NIB_READY) begin
      out_stage_v_reg <= 1'b0;
    end
  end
endmodule // e3ntx_payload_in
`default_nettype wire

// ---- pkg/e3ntx_defines.vh ----
// Constants for the E3 nibble transmit payload input block
`ifndef E3NTX_DEFINES_VH
`define E3NTX_DEFINES_VH
`define E3NTX_ADDR_W        8
`define E3NTX_ADDR_MODE     8'h00
`define E3NTX_ADDR_STATUS   8'h01
`define E3NTX_ADDR_NIBBLE   8'h02
`define E3NTX_MODE_RESET    8'h28
`define E3NTX_B_LOOPBACK    7
`define E3NTX_B_LINESTD     6
`define E3NTX_B_LOSEN       5
`define E3NTX_B_SWRESET     4
`define E3NTX_B_INTENRST    3
`define E3NTX_B_FORMAT      2
`define E3NTX_B_SEL_HI      1
`define E3NTX_B_SEL_LO      0
`define E3NTX_SEL_OFF       2'h0
`define E3NTX_SEL_SLAVE     2'h1
`define E3NTX_DIV           2'h3
`define E3NTX_DIV_HALF      2'h2
`define E3NTX_SAMPLE_DLY    2'h3
`define E3NTX_BITS_FRAME    11'h600
`define E3NTX_BITS_PAYLOAD  11'h5F4
`define E3NTX_BITS_OH       11'h00C
`define E3NTX_NIB_LAST      9'h17F
`define E3NTX_BIT_LAST      2'h3
`define E3NTX_OH_NIBBLES    9'h003
`define E3NTX_FIFO_DEPTH    8
`define E3NTX_FIFO_AW       3
`define E3NTX_NIB_W         4
`endif

// ---- test/e3ntx_payload_in_bench.sv ----
// Self-checking bench for the E3 nibble payload input
`timescale 1ns/10ps
`default_nettype none
module e3ntx_payload_in_bench;
  logic        CLK, NRST, WR, RD, NIBBLE_INTF_EN, NIB_READY, frame_go, cmp_on;
  logic [7:0]  ADDR, WDATA, RDATA, v, wd;
  logic [3:0]  TX_PAYLOAD_NIBBLE, NIB_DATA, q;
  logic        TX_FRAME_REF_IN, TX_NIBBLE_CLOCK_OUT, TX_FRAME_BOUNDARY_OUT, NIB_FIRST;
  logic        TX_OVERHEAD_INDICATOR, NIB_OVERHEAD, NIB_VALID, TX_ACTIVE;
  logic [10:0] cnt, nfirst;
  integer      seed, n_fail, n_checks, i;
  e3ntx_payload_in e3ntx_payload_in_inst (.*);
  e3ntx_term e3ntx_term_inst (.*);
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic chk(input [10:0] got, input [10:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, output [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask
  function automatic logic exp_oh(input [10:0] c);
    return c < 11'h003;
  endfunction
  task final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // While cmp_on is set, each accepted nibble pairs with one nibble the terminal launched
  always @(posedge CLK) begin
    if (NIB_VALID === 1'b1 && NIB_READY) begin
      if (NIB_FIRST) begin
        if (cmp_on && nfirst != 0) chk(cnt, 11'h180);
        nfirst = nfirst + 1;
        cnt = 0;
      end
      if (cmp_on) begin
        q = e3ntx_term_inst.sent.pop_front();
        if (nfirst != 0) chk(NIB_OVERHEAD, exp_oh(cnt));
        if (nfirst != 0) chk(NIB_DATA, exp_oh(cnt) ? 4'h0 : q);
      end
      cnt = cnt + 1;
    end
  end
  initial begin
    seed = 32'h87B12624;
    n_fail = 0;
    n_checks = 0;
    cnt = 0;
    nfirst = 0;
    cmp_on = 0;
    NRST = 0;
    WR = 0;
    RD = 0;
    ADDR = 0;
    WDATA = 0;
    NIBBLE_INTF_EN = 1;
    NIB_READY = 1;
    frame_go = 0;
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    rd(8'h00, v);
    chk(v, 8'h28);
    rd(8'h7F, v);
    chk(v, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wd = $random(seed) & 8'hEC;
      wr(8'h00, wd);
      rd(8'h00, v);
      chk(v, wd);
    end
    // Both master codes, far side stalling at random
    for (i = 2; i < 4; i = i + 1) begin
      wr(8'h00, 8'h28);
      repeat (40) @(posedge CLK);
      e3ntx_term_inst.sent.delete();
      nfirst = 0;
      cmp_on = 1;
      wr(8'h00, 8'h28 | i[7:0]);
      repeat (3400) begin
        @(posedge CLK);
        NIB_READY <= ($random(seed) & 3) != 0;
      end
      chk(TX_ACTIVE, 1'b1);
      @(posedge CLK);
      NIB_READY <= 1'b1;
      cmp_on = 0;
      chk(nfirst >= 2, 1'b1);
    end
    NIBBLE_INTF_EN <= 1'b0;
    repeat (100) @(posedge CLK);
    NIBBLE_INTF_EN <= 1'b1;
    // Second reference lands mid-frame; slave waits for the first one
    wr(8'h00, 8'h28);
    wr(8'h00, 8'h29);
    repeat (60) @(posedge CLK);
    chk(TX_ACTIVE, 1'b0);
    nfirst = 0;
    for (i = 0; i < 2; i = i + 1) begin
      frame_go <= 1'b1;
      @(posedge CLK);
      frame_go <= 1'b0;
      repeat (800) @(posedge CLK);
    end
    chk(nfirst, 2);
    chk(TX_ACTIVE, 1'b1);
    // Overrun drops data, so pairing is off from here on
    wr(8'h00, 8'h2A);
    NIB_READY <= 1'b0;
    repeat (80) @(posedge CLK);
    rd(8'h01, v);
    chk(v[7:3], 5'h18);
    wr(8'h00, 8'h28);
    wr(8'h01, 8'h00);
    NIB_READY <= 1'b1;
    rd(8'h01, v);
    chk(v[7], 1'b0);
    repeat (40) @(posedge CLK);
    rd(8'h01, v);
    chk(v[6:3], 4'h0);
    final_report;
  end
  initial begin
    #100000;
    n_fail = n_fail + 1;
    final_report;
  end
endmodule // e3ntx_payload_in_bench
`default_nettype wire

// ---- test/e3ntx_sva.sv ----
// Assertion checker for the E3 nibble payload input
`timescale 1ns/10ps
`default_nettype none
module e3ntx_sva (
  input wire logic       CLK,
  input wire logic       NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       NIBBLE_INTF_EN,
  input wire logic       TX_FRAME_REF_IN,
  input wire logic       TX_NIBBLE_CLOCK_OUT,
  input wire logic       TX_FRAME_BOUNDARY_OUT,
  input wire logic       TX_OVERHEAD_INDICATOR,
  input wire logic       NIB_FIRST,
  input wire logic       NIB_VALID,
  input wire logic       NIB_READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [7:0]  mode_q;
  logic [10:0] gap;
  logic        seen;
  wire         nck = TX_NIBBLE_CLOCK_OUT;
  wire         fb = TX_FRAME_BOUNDARY_OUT;
  wire         mwr = WR && ADDR == 8'h00;
  wire         off = !NIBBLE_INTF_EN || mode_q[1:0] == 2'h0 || mode_q[4];
  wire         slave = !off && mode_q[1:0] == 2'h1;
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_q <= 8'h28;
      gap    <= 11'h000;
      seen   <= 1'b0;
    end else begin
      mode_q <= mwr ? WDATA : mode_q;
      gap    <= fb ? 11'h000 : gap + 11'h001;
      // Forget the marker on a mode change, else the gap spans two runs
      seen   <= !off && !mwr && (seen || fb);
    end
  end
  nck_shape_a: assert property (disable iff (!NRST || off || slave)
    $rose(nck) |=> nck ##1 (!nck) [*2] ##1 nck) else $error("nibble clock shape");
  nck_quiet_a: assert property (off && $past(off) && $past(off, 2) |-> !$rose(nck))
    else $error("nibble clock while off");
  oh_low_a: assert property (TX_OVERHEAD_INDICATOR == 1'b0)
    else $error("overhead indicator high");
  fb_pulse_a: assert property (fb |=> !fb)
    else $error("boundary pulse too long");
  frame_gap_a: assert property (fb && seen |-> gap == 11'h5FF)
    else $error("frame length wrong");
  ref_start_a: assert property (slave && $rose(TX_FRAME_REF_IN) && NIB_READY
    |-> ##[1:20] NIB_VALID && NIB_FIRST) else $error("no frame start after ref");
  rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside slot");
  rd_mode_a: assert property ($past(RD) && $past(ADDR) == 8'h00 |-> RDATA == mode_q)
    else $error("mode read wrong");
endmodule // e3ntx_sva
bind e3ntx_payload_in e3ntx_sva e3ntx_sva_inst (.*);
`default_nettype wire

// ---- test/e3ntx_term.sv ----
// Terminal equipment model feeding payload nibbles
`timescale 1ns/10ps
`default_nettype none
module e3ntx_term (
  input  wire logic       CLK,
  input  wire logic       TX_NIBBLE_CLOCK_OUT,
  input  wire logic       frame_go,
  output var  logic [3:0] TX_PAYLOAD_NIBBLE,
  output var  logic       TX_FRAME_REF_IN
);
  logic [3:0] sent[$];
  initial begin
    TX_PAYLOAD_NIBBLE = 4'h0;
    TX_FRAME_REF_IN   = 1'b0;
  end
  // Odd step, so every value comes round
  always @(posedge TX_NIBBLE_CLOCK_OUT) begin
    TX_PAYLOAD_NIBBLE <= TX_PAYLOAD_NIBBLE + 4'h7;
    sent.push_back(TX_PAYLOAD_NIBBLE + 4'h7);
  end
  always @(posedge CLK) begin
    TX_FRAME_REF_IN <= frame_go;
  end
endmodule // e3ntx_term
`default_nettype wire
